// [ffs_checker.sv]
// Purpose: Port-level assertions for the feeder fault supervisor.
// Assumes: TICK_CNT equals that of the bound instance.
// Notes:   Counters stand in for waits too long to unroll.
`timescale 1ns/1ps
module ffs_checker
  import ffs_pkg::*;
#(
  parameter int unsigned TICK_CNT = 10
) (
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic              trigger_pin,
  input wire logic              motor_overload_pin,
  input wire logic              ground_fault_pin,
  input wire logic              cold_fwd_pin,
  input wire logic              cold_rev_pin,
  input wire logic              cold_trig_mode,
  input wire logic [11:0]       arc_voltage_dv,
  input wire logic              motor_run,
  input wire logic              gas_valve,
  input wire logic              source_enable,
  input wire logic              weld_voltage_on,
  input wire ffs_pkg::ffs_sym_t feed_speed_display,
  input wire ffs_pkg::ffs_sym_t volt_display,
  input wire logic [5:0]        overload_countdown_code,
  input wire logic [2:0]        accel_value
);
  logic [31:0] low_q, low_d;
  logic [15:0] held_q, held_d;
  logic        low_now, ovl, gnd;

  // Overload and ground faults and cold feed are left out so the count sees a plain sense loss only.
  assign low_now = trigger_pin && arc_voltage_dv < SENSE_MIN_DV && !motor_overload_pin
                   && !ground_fault_pin && !cold_fwd_pin && !cold_rev_pin && !cold_trig_mode;
  assign ovl = feed_speed_display == FFS_SYM_OVL;
  assign gnd = feed_speed_display == FFS_SYM_GROUND;

  always_comb begin
    low_d  = low_now ? low_q + {31'h0, ~&low_q} : 32'h0;
    held_d = trigger_pin ? held_q + {15'h0, ~&held_q} : 16'h0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_q  <= 32'h0;
      held_q <= 16'h0;
    end else begin
      low_q  <= low_d;
      held_q <= held_d;
    end
  end

//////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sense_loss_a: assert property (
    low_q == 32'(12 * TICK_CNT) |-> !source_enable && !motor_run && !gas_valve)
    else $error("outputs still on after a long low arc voltage");
  ovl_outputs_a: assert property (
    ovl |-> volt_display == FFS_SYM_BLANK && !source_enable && !motor_run && !gas_valve)
    else $error("overload view with outputs or voltage display active");
  ovl_entry_a: assert property ($rose(ovl) |-> overload_countdown_code == OVL_START_SEC)
    else $error("overload countdown did not start at thirty");
  ovl_step_a: assert property (
    $changed(overload_countdown_code) && ovl && $past(ovl)
      |-> overload_countdown_code == $past(overload_countdown_code) - 6'h01)
    else $error("overload countdown moved by other than one");
  gnd_outputs_a: assert property (
    gnd |-> volt_display == FFS_SYM_BLANK && !source_enable && !motor_run && !gas_valve)
    else $error("ground view with outputs or voltage display active");
  gnd_hold_a: assert property (gnd && held_q >= 16'h0008 |=> gnd)
    else $error("ground code cleared while the trigger stayed closed");
  cold_out_a: assert property (
    volt_display == FFS_SYM_COLD |-> !weld_voltage_on && !source_enable && !gas_valve)
    else $error("cold feed with weld voltage or gas on");
  accel_range_a: assert property (accel_value >= 3'h1 && accel_value <= 3'h5)
    else $error("acceleration value out of range");
endmodule : ffs_checker

bind ffs_supervisor ffs_checker #(.TICK_CNT(TICK_CNT)) i_ffs_checker (
  .clk(clk), .arst_n(arst_n), .trigger_pin(trigger_pin),
  .motor_overload_pin(motor_overload_pin), .ground_fault_pin(ground_fault_pin),
  .cold_fwd_pin(cold_fwd_pin), .cold_rev_pin(cold_rev_pin), .cold_trig_mode(cold_trig_mode),
  .arc_voltage_dv(arc_voltage_dv), .motor_run(motor_run), .gas_valve(gas_valve),
  .source_enable(source_enable), .weld_voltage_on(weld_voltage_on),
  .feed_speed_display(feed_speed_display), .volt_display(volt_display),
  .overload_countdown_code(overload_countdown_code), .accel_value(accel_value)
);

// [ffs_pkg.sv]
// Purpose: Shared constants and types for the feeder fault supervisor.
// Assumes: 100 MHz system clock, APB register access with 32-bit data.
// Notes:   Display symbols are codes that a separate glyph driver renders.
package ffs_pkg;

  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_MS         = 100;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_SEC   = 10;
  localparam int unsigned SENSE_LOSS_MS   = 800;
  localparam int unsigned SENSE_LOSS_TKS  = SENSE_LOSS_MS / TICK_MS;
  // Arc voltage in tenths of a volt.
  localparam logic [11:0] SENSE_MIN_DV    = 12'h050;
  localparam logic [5:0]  OVL_START_SEC   = 6'h1E;

  // Register byte offsets.
  localparam logic [11:0] REG_CTRL        = 12'h000;
  localparam logic [11:0] REG_STATUS      = 12'h004;
  localparam logic [11:0] REG_IRQ_STAT    = 12'h008;
  localparam logic [11:0] REG_IRQ_MASK    = 12'h00C;
  localparam logic [11:0] REG_DISP_FEED   = 12'h010;
  localparam logic [11:0] REG_DISP_VOLT   = 12'h014;

  // Control field positions.
  localparam int unsigned CTRL_ACC_SHOW   = 0;
  localparam int unsigned CTRL_TIMER_SHOW = 1;
  localparam int unsigned CTRL_FEED_OFF   = 2;
  localparam int unsigned CTRL_VOLT_OFF   = 3;
  localparam int unsigned CTRL_RUNIN      = 4;
  localparam int unsigned CTRL_RUNIN_FEED = 5;
  localparam int unsigned CTRL_RUNIN_VOLT = 6;
  localparam int unsigned CTRL_ACC_LSB    = 8;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0100;

  // Interrupt bit positions.
  localparam int unsigned IRQ_SENSE       = 0;
  localparam int unsigned IRQ_OVL         = 1;
  localparam int unsigned IRQ_GND         = 2;
  localparam int unsigned IRQ_SET_ERR     = 3;
  localparam int unsigned IRQ_W           = 4;

  typedef enum logic [3:0] {
    FFS_SYM_VALUE   = 4'h0,
    FFS_SYM_BLANK   = 4'h1,
    FFS_SYM_OFF     = 4'h2,
    FFS_SYM_DASHES  = 4'h3,
    FFS_SYM_ACC     = 4'h4,
    FFS_SYM_SECONDS = 4'h5,
    FFS_SYM_GROUND  = 4'h6,
    FFS_SYM_OVL     = 4'h7,
    FFS_SYM_SET_ERR = 4'h8,
    FFS_SYM_COLD    = 4'h9
  } ffs_sym_t;

  typedef enum logic [2:0] {
    FFS_ST_RUN      = 3'b000,
    FFS_ST_SENSE    = 3'b001,
    FFS_ST_OVL      = 3'b010,
    FFS_ST_GND_HOLD = 3'b011,
    FFS_ST_GND_ARM  = 3'b100,
    FFS_ST_SET_ERR  = 3'b101
  } ffs_state_t;

endpackage : ffs_pkg

// [ffs_source_model.sv]
// Purpose: Power source, sense leads and drive motor seen from the supervisor.
// Assumes: Sensed voltage follows the enables one clock later.
// Notes:   An open sense lead reads zero, as a broken feedback path would.
`timescale 1ns/1ps
module ffs_source_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        source_enable,
  input  wire logic        weld_voltage_on,
  input  wire logic        motor_run,
  input  wire logic        sense_open,
  input  wire logic        jam,
  input  wire logic [11:0] set_dv,
  output logic      [11:0] arc_voltage_dv,
  output logic             motor_overload_pin
);
  logic [11:0] arc_q, arc_d;

  always_comb begin
    arc_d = (source_enable && weld_voltage_on && !sense_open) ? set_dv : 12'h000;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      arc_q <= 12'h000;
    end else begin
      arc_q <= arc_d;
    end
  end

  assign arc_voltage_dv     = arc_q;
  // A jammed wire only loads the motor while it turns.
  assign motor_overload_pin = jam && motor_run;
endmodule : ffs_source_model

// [ffs_supervisor.sv]
// Purpose: Fault supervision and display selection for a wire feeder.
// Assumes: Pins are asynchronous; arc voltage comes from an ADC in 0.1 V steps.
// Notes:   Only one fault state is held at a time; entry order is fixed.
// Behaviour
// - Low arc voltage over 0.8 s latches shutdown.
// - Sense loss stops motor, gas, output enable.
// - Overload disables outputs, shows H30, blanks voltage.
// - Count down each second; at zero restore.
// - Ground fault shows code, blanks, disables outputs.
// - Trigger release, then key or trigger clears.
// - Bad recalled settings show error until key.
// - Cold feed shows indicator, feeds without voltage.
// - Acceleration indicator with setting one to five.
// - Timer view shows seconds indicator on feed.
// - Disabled limit shows OFF on its display.
// - Run-in following weld setting shows dashes.
`timescale 1ns/1ps
module ffs_supervisor #(
  parameter int unsigned TICK_CNT = ffs_pkg::TICK_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              trigger_pin,
  input  wire logic              motor_overload_pin,
  input  wire logic              ground_fault_pin,
  input  wire logic              key_pin,
  input  wire logic              cold_fwd_pin,
  input  wire logic              cold_rev_pin,
  input  wire logic              cold_trig_mode,
  input  wire logic [11:0]       arc_voltage_dv,
  input  wire logic              settings_valid,
  input  wire logic              settings_bad,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   motor_run,
  output logic                   motor_reverse,
  output logic                   gas_valve,
  output logic                   source_enable,
  output logic                   weld_voltage_on,
  output ffs_pkg::ffs_sym_t      feed_speed_display,
  output ffs_pkg::ffs_sym_t      volt_display,
  output logic      [5:0]        overload_countdown_code,
  output logic      [2:0]        accel_value,
  output logic                   irq
);
  import ffs_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  logic [5:0] pins_s;
  logic       trig_s;
  logic       ovl_s;
  logic       gnd_s;
  logic       key_s;
  logic       cfwd_s;
  logic       crev_s;

  ffs_sync #(.W(6)) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({trigger_pin, motor_overload_pin, ground_fault_pin,
              key_pin, cold_fwd_pin, cold_rev_pin}),
    .dout   (pins_s)
  );
  assign {trig_s, ovl_s, gnd_s, key_s, cfwd_s, crev_s} = pins_s;

  logic key_prev_q;
  logic key_prev_d;
  logic trig_prev_q;
  logic trig_prev_d;
  logic key_press;
  logic trig_close;

  always_comb begin
    key_prev_d  = key_s;
    trig_prev_d = trig_s;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_prev_q  <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      key_prev_q  <= key_prev_d;
      trig_prev_q <= trig_prev_d;
    end
  end

  assign key_press  = key_s & ~key_prev_q;
  assign trig_close = trig_s & ~trig_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // Time base.

  logic [31:0] div_q;
  logic [31:0] div_d;
  logic [3:0]  tenth_q;
  logic [3:0]  tenth_d;
  logic        tick;
  logic        sec_tick;

  always_comb begin
    tick     = (div_q == TICK_CNT - 1);
    div_d    = tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
    sec_tick = tick && (tenth_q == 4'(TICKS_PER_SEC - 1));
    tenth_d  = tenth_q;
    if (tick) begin
      tenth_d = sec_tick ? 4'h0 : tenth_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q   <= 32'h0000_0000;
      tenth_q <= 4'h0;
    end else begin
      div_q   <= div_d;
      tenth_q <= tenth_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fault state machine.

  ffs_state_t  st_q;
  ffs_state_t  st_d;
  logic [3:0]  low_q;
  logic [3:0]  low_d;
  logic [5:0]  cnt_q;
  logic [5:0]  cnt_d;
  logic        low_volt;

  assign low_volt = trig_s && !(cfwd_s || crev_s || cold_trig_mode)
                    && (arc_voltage_dv < SENSE_MIN_DV);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    low_d = low_q;
    if (!low_volt) begin
      low_d = 4'h0;
    end else if (tick && low_q <= 4'(SENSE_LOSS_TKS)) begin
      low_d = low_q + 4'h1;
    end
    case (st_q)
      FFS_ST_RUN: begin
        if (gnd_s) begin
          st_d = FFS_ST_GND_HOLD;
        end else if (ovl_s) begin
          st_d  = FFS_ST_OVL;
          cnt_d = OVL_START_SEC;
        end else if (settings_valid && settings_bad) begin
          st_d = FFS_ST_SET_ERR;
        end else if (low_q > 4'(SENSE_LOSS_TKS)) begin
          st_d = FFS_ST_SENSE;
        end
      end
      FFS_ST_SENSE: begin
        if (!trig_s) begin
          st_d = FFS_ST_RUN;
        end
      end
      FFS_ST_OVL: begin
        if (sec_tick) begin
          if (cnt_q == 6'h00) begin
            st_d = FFS_ST_RUN;
          end else begin
            cnt_d = cnt_q - 6'h01;
          end
        end
      end
      FFS_ST_GND_HOLD: begin
        if (!trig_s) begin
          st_d = FFS_ST_GND_ARM;
        end
      end
      FFS_ST_GND_ARM: begin
        if (key_press || trig_close) begin
          st_d = FFS_ST_RUN;
        end
      end
      FFS_ST_SET_ERR: begin
        if (key_press) begin
          st_d = FFS_ST_RUN;
        end
      end
      default: st_d = FFS_ST_RUN;
    endcase
    if (st_q != FFS_ST_RUN) begin
      low_d = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= FFS_ST_RUN;
      cnt_q <= 6'h00;
      low_q <= 4'h0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB registers and interrupts.

  logic [31:0]       ctrl_q;
  logic [31:0]       ctrl_d;
  logic [IRQ_W-1:0]  ist_q;
  logic [IRQ_W-1:0]  ist_d;
  logic [IRQ_W-1:0]  imask_q;
  logic [IRQ_W-1:0]  imask_d;
  logic [IRQ_W-1:0]  ev;
  logic              acc;
  logic              wr;
  logic              mapped;
  logic              cold;
  logic              fault;

  assign acc  = psel && penable;
  assign wr   = acc && pwrite;
  assign cold = cfwd_s || crev_s || cold_trig_mode;
  assign fault = (st_q != FFS_ST_RUN);

  // Events are one-cycle entries into each fault state except FFS_ST_GND_ARM.
  always_comb begin
    ev              = '0;
    ev[IRQ_SENSE]   = (st_d == FFS_ST_SENSE)    && (st_q != FFS_ST_SENSE);
    ev[IRQ_OVL]     = (st_d == FFS_ST_OVL)      && (st_q != FFS_ST_OVL);
    ev[IRQ_GND]     = (st_d == FFS_ST_GND_HOLD) && (st_q != FFS_ST_GND_HOLD);
    ev[IRQ_SET_ERR] = (st_d == FFS_ST_SET_ERR)  && (st_q != FFS_ST_SET_ERR);
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    if (wr && paddr == REG_CTRL) begin
      ctrl_d = pwdata;
    end
    if (wr && paddr == REG_IRQ_MASK) begin
      imask_d = pwdata[IRQ_W-1:0];
    end
    if (wr && paddr == REG_IRQ_STAT) begin
      ist_d = ist_q & ~pwdata[IRQ_W-1:0];
    end
    // Setting after clearing lets a same-cycle event survive the clear.
    ist_d = ist_d | ev;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= CTRL_RESET;
      imask_q <= '0;
      ist_q   <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      imask_q <= imask_d;
      ist_q   <= ist_d;
    end
  end

  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      REG_CTRL:      prdata = ctrl_q;
      REG_STATUS:    prdata = {23'h0, cnt_q, st_q};
      REG_IRQ_STAT:  prdata = {28'h0, ist_q};
      REG_IRQ_MASK:  prdata = {28'h0, imask_q};
      REG_DISP_FEED: prdata = {28'h0, feed_speed_display};
      REG_DISP_VOLT: prdata = {28'h0, volt_display};
      default:       mapped = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;
  assign irq     = |(ist_q & imask_q);

  //////////////////////////////////////////////////////////////////////////////
  // Outputs and display selection.

  logic [2:0] acc_raw;
  assign acc_raw = ctrl_q[CTRL_ACC_LSB +: 3];

  always_comb begin
    // Every fault drops motor, gas and power source together.
    motor_run       = trig_s && !fault || (cold && !fault);
    motor_reverse   = crev_s && !fault;
    gas_valve       = trig_s && !fault && !cold;
    source_enable   = trig_s && !fault && !cold;
    weld_voltage_on = source_enable;
    overload_countdown_code = (st_q == FFS_ST_OVL) ? cnt_q : 6'h00;
    // Settings outside 1..5 are clamped so the display stays in range.
    if (acc_raw < 3'h1) begin
      accel_value = 3'h1;
    end else if (acc_raw > 3'h5) begin
      accel_value = 3'h5;
    end else begin
      accel_value = acc_raw;
    end
    feed_speed_display = FFS_SYM_VALUE;
    volt_display       = FFS_SYM_VALUE;
    case (st_q)
      FFS_ST_OVL: begin
        feed_speed_display = FFS_SYM_OVL;
        volt_display       = FFS_SYM_BLANK;
      end
      FFS_ST_GND_HOLD, FFS_ST_GND_ARM: begin
        feed_speed_display = FFS_SYM_GROUND;
        volt_display       = FFS_SYM_BLANK;
      end
      FFS_ST_SET_ERR: begin
        feed_speed_display = FFS_SYM_SET_ERR;
      end
      default: begin
        if (cold) begin
          volt_display = FFS_SYM_COLD;
        end else if (ctrl_q[CTRL_ACC_SHOW]) begin
          volt_display = FFS_SYM_ACC;
        end else if (ctrl_q[CTRL_TIMER_SHOW]) begin
          feed_speed_display = FFS_SYM_SECONDS;
        end else begin
          if (ctrl_q[CTRL_RUNIN] && ctrl_q[CTRL_RUNIN_FEED]) begin
            feed_speed_display = FFS_SYM_DASHES;
          end else if (ctrl_q[CTRL_FEED_OFF]) begin
            feed_speed_display = FFS_SYM_OFF;
          end
          if (ctrl_q[CTRL_RUNIN] && ctrl_q[CTRL_RUNIN_VOLT]) begin
            volt_display = FFS_SYM_DASHES;
          end else if (ctrl_q[CTRL_VOLT_OFF]) begin
            volt_display = FFS_SYM_OFF;
          end
        end
      end
    endcase
  end

endmodule : ffs_supervisor

// [ffs_supervisor_tb.sv]
// Purpose: Self-checking bench for the feeder fault supervisor.
// Assumes: TICK_CNT shortened so one second is 100 clocks.
// Notes:   Display expectations follow the priority cold, acc, timer, run-in, off.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module ffs_supervisor_tb
  import ffs_pkg::*;
;
  localparam int unsigned TK  = 10;
  localparam int unsigned SEC = 10 * TK;
  logic        clk, arst_n, trigger_pin, motor_overload_pin, ground_fault_pin, key_pin;
  logic        cold_fwd_pin, cold_rev_pin, cold_trig_mode, settings_valid, settings_bad;
  logic        psel, penable, pwrite, pready, pslverr, motor_run, motor_reverse, gas_valve;
  logic        source_enable, weld_voltage_on, irq, sense_open, jam, err;
  logic [11:0] arc_voltage_dv, paddr, set_dv;
  logic [31:0] pwdata, prdata, q, c;
  logic [5:0]  overload_countdown_code;
  logic [2:0]  accel_value;
  ffs_sym_t    feed_speed_display, volt_display;
  int          errors, num_checks, seed, n;

  ffs_supervisor #(.TICK_CNT(TK)) i_ffs_supervisor (.clk(clk), .arst_n(arst_n),
    .trigger_pin(trigger_pin), .motor_overload_pin(motor_overload_pin),
    .ground_fault_pin(ground_fault_pin), .key_pin(key_pin), .cold_fwd_pin(cold_fwd_pin),
    .cold_rev_pin(cold_rev_pin), .cold_trig_mode(cold_trig_mode),
    .arc_voltage_dv(arc_voltage_dv), .settings_valid(settings_valid),
    .settings_bad(settings_bad), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_run(motor_run), .motor_reverse(motor_reverse), .gas_valve(gas_valve),
    .source_enable(source_enable), .weld_voltage_on(weld_voltage_on),
    .feed_speed_display(feed_speed_display), .volt_display(volt_display),
    .overload_countdown_code(overload_countdown_code), .accel_value(accel_value), .irq(irq));
  ffs_source_model i_ffs_source_model (.clk(clk), .arst_n(arst_n),
    .source_enable(source_enable), .weld_voltage_on(weld_voltage_on), .motor_run(motor_run),
    .sense_open(sense_open), .jam(jam), .set_dv(set_dv), .arc_voltage_dv(arc_voltage_dv),
    .motor_overload_pin(motor_overload_pin));

//////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_disp(input logic [31:0] v, input logic cold);
    if (cold) return {FFS_SYM_VALUE, FFS_SYM_COLD};
    if (v[CTRL_ACC_SHOW]) return {FFS_SYM_VALUE, FFS_SYM_ACC};
    if (v[CTRL_TIMER_SHOW]) return {FFS_SYM_SECONDS, FFS_SYM_VALUE};
    return {(v[CTRL_RUNIN] && v[CTRL_RUNIN_FEED]) ? FFS_SYM_DASHES
              : v[CTRL_FEED_OFF] ? FFS_SYM_OFF : FFS_SYM_VALUE,
            (v[CTRL_RUNIN] && v[CTRL_RUNIN_VOLT]) ? FFS_SYM_DASHES
              : v[CTRL_VOLT_OFF] ? FFS_SYM_OFF : FFS_SYM_VALUE};
  endfunction : exp_disp

  function automatic logic [2:0] clamp(input logic [2:0] a);
    return (a == 3'h0) ? 3'h1 : (a > 3'h5) ? 3'h5 : a;
  endfunction : clamp

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // The request is held until pready is seen; one idle edge follows so calls never collide.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      test_done();
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_sym(input ffs_sym_t s, input logic eq, input int lim);
    n = 0;
    while (((feed_speed_display === s) != eq) && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      errors++;
      test_done();
    end
  endtask : wait_sym

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    seed = 80750;
    {arst_n, trigger_pin, ground_fault_pin, key_pin, cold_fwd_pin, cold_rev_pin} = '0;
    {cold_trig_mode, settings_valid, settings_bad, psel, penable, pwrite, sense_open} = '0;
    {jam, paddr, pwdata} = '0;
    set_dv = 12'h0F0;
    cyc(2);
    arst_n <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl reset", CTRL_RESET, q)
    apb(1'b0, REG_IRQ_MASK, 32'h0);
    `CHK("mask reset", 32'h0, q)
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    `CHK("unmapped err", 1'b1, err)
    for (int i = 0; i < 24; i++) begin
      c = {21'h0, 3'($random(seed)), 1'b0, 7'($random(seed))};
      if (i < 2) c = i ? 32'h0000_0770 : 32'h0000_000C;
      apb(1'b1, REG_CTRL, c);
      `CHK("display", exp_disp(c, 1'b0), {feed_speed_display, volt_display})
      `CHK("accel", clamp(c[10:8]), accel_value)
    end
    apb(1'b1, REG_CTRL, CTRL_RESET);
    for (int i = 0; i < 3; i++) begin
      {cold_trig_mode, cold_rev_pin, cold_fwd_pin} <= 3'(1 << i);
      trigger_pin <= (i == 2);
      cyc(i == 2 ? 12 * TK : 4);
      `CHK("cold view", exp_disp(CTRL_RESET, 1'b1), {feed_speed_display, volt_display})
      `CHK("cold out", {1'b1, i == 1, 3'h0},
        {motor_run, motor_reverse, weld_voltage_on, gas_valve, source_enable})
      {cold_trig_mode, cold_rev_pin, cold_fwd_pin, trigger_pin} <= 4'h0;
      cyc(4);
    end
    apb(1'b1, REG_IRQ_MASK, 32'h0000_000F);
    trigger_pin <= 1'b1;
    cyc(6);
    `CHK("weld on", 4'hF, {source_enable, motor_run, gas_valve, weld_voltage_on})
    sense_open <= 1'b1;
    cyc(7 * TK);
    `CHK("no early stop", 1'b1, source_enable)
    cyc(4 * TK);
    `CHK("sense stop", 3'h0, {source_enable, motor_run, gas_valve})
    sense_open <= 1'b0;
    cyc(3 * TK);
    `CHK("sense held", 1'b0, source_enable)
    trigger_pin <= 1'b0;
    cyc(4);
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, REG_IRQ_MASK, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, REG_IRQ_STAT, 32'h0000_0001);
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    `CHK("irq cleared", 32'h0, q)
    apb(1'b1, REG_IRQ_MASK, 32'h0000_000F);
    trigger_pin <= 1'b1;
    cyc(6);
    `CHK("sense exit", 1'b1, source_enable)
    jam <= 1'b1;
    wait_sym(FFS_SYM_OVL, 1'b1, 20);
    jam <= 1'b0;
    trigger_pin <= 1'b0;
    `CHK("ovl code", OVL_START_SEC, overload_countdown_code)
    `CHK("ovl view", {FFS_SYM_OVL, FFS_SYM_BLANK, 3'h0},
      {feed_speed_display, volt_display, source_enable, motor_run, gas_valve})
    wait_sym(FFS_SYM_OVL, 1'b0, 40 * SEC);
    `CHK("ovl length", 1'b1, n >= 30 * SEC - TK && n <= 31 * SEC + TK)
    `CHK("ovl restore", exp_disp(CTRL_RESET, 1'b0), {feed_speed_display, volt_display})
    for (int m = 0; m < 2; m++) begin
      trigger_pin <= 1'b1;
      ground_fault_pin <= 1'b1;
      wait_sym(FFS_SYM_GROUND, 1'b1, 20);
      ground_fault_pin <= 1'b0;
      cyc(2);
      `CHK("gnd view", {FFS_SYM_GROUND, FFS_SYM_BLANK, 3'h0},
        {feed_speed_display, volt_display, source_enable, motor_run, gas_valve})
      key_pin <= 1'b1;
      cyc(4);
      key_pin <= 1'b0;
      cyc(4);
      `CHK("gnd key held", FFS_SYM_GROUND, feed_speed_display)
      trigger_pin <= 1'b0;
      cyc(6);
      `CHK("gnd armed", FFS_SYM_GROUND, feed_speed_display)
      if (m == 1) trigger_pin <= 1'b1;
      else key_pin <= 1'b1;
      cyc(6);
      key_pin <= 1'b0;
      `CHK("gnd cleared", FFS_SYM_VALUE, feed_speed_display)
      trigger_pin <= 1'b0;
      cyc(4);
    end
    {settings_valid, settings_bad} <= 2'b11;
    cyc(3);
    {settings_valid, settings_bad} <= 2'b00;
    cyc(12);
    `CHK("set err", 1'b1, feed_speed_display === FFS_SYM_SET_ERR)
    key_pin <= 1'b1;
    cyc(4);
    key_pin <= 1'b0;
    cyc(2);
    `CHK("set err gone", exp_disp(CTRL_RESET, 1'b0), {feed_speed_display, volt_display})
    apb(1'b0, REG_IRQ_STAT, 32'h0);
    `CHK("irq status", 32'h0000_000E, q)
    apb(1'b1, REG_IRQ_STAT, 32'h0000_000E);
    `CHK("irq low", 1'b0, irq)
    test_done();
  end
endmodule : ffs_supervisor_tb

// [ffs_sync.sv]
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
module ffs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule : ffs_sync
